/* dv/extended_bank_select_tb.sv */
// Self-checking bench for the bank controller end and the memory board end
`timescale 1ns/1ps
`include "xbs_defs.svh"
module extended_bank_select_tb
   import xbs_pkg::*;
;
   logic mclk, srst, cmd_valid, phantom_req, cmd_ready, cmd_done, prog_we;
   logic ext_fitted, src_latch, decoded_form, a11_invert, disables_as_inputs;
   logic memory_selected_n, board_select_n, bank_enable_n, access_req, ext_addr_latch_clk;
   logic mid_bank, mid_acc;
   xbs_cmd_type cmd_kind;
   logic [15:0] cmd_addr;
   logic [7:0] cmd_data, block_switch, prog_addr, ext_latch, v;
   logic [3:0] strobe_sel, prog_data;
   logic [1:0] out_sel, prog_table;
   logic [7:0] one_hot [5] = '{8'h03, 8'h04, 8'h00, 8'hC0, 8'h08};
   logic [15:0] blk_addr [4] = '{16'hF000, 16'hE000, 16'h7000, 16'hF000};
   logic [7:0] blk_sw [4] = '{8'h53, 8'h53, 8'h53, 8'h00};
   logic [3:0] blk_dis = 4'b0011;
   logic [15:0] bad_addr [3] = '{16'hCE00, 16'hC700, 16'hDF00};
   int error_cnt, checks_done, cyc;

   xbs_if bus ();
   xbs_host u_xbs_host (.mclk, .srst, .bus(bus), .cmd_valid, .cmd_kind, .cmd_addr, .cmd_data, .phantom_req,
      .cmd_ready, .cmd_done);
   xbs_device u_xbs_device (.mclk, .srst, .bus(bus), .ext_fitted, .src_latch, .decoded_form, .strobe_sel,
      .a11_invert, .out_sel, .disables_as_inputs, .block_switch, .memory_selected_n, .board_select_n, .prog_we,
      .prog_table, .prog_addr, .prog_data, .bank_enable_n, .access_req, .ext_addr_latch_clk, .ext_latch);
   xbs_asserts u_xbs_asserts (.mclk, .srst, .phase2(bus.phase2), .psync(bus.psync), .pwr_n(bus.pwr_n),
      .sout(bus.sout), .addr(bus.addr), .do_bus(bus.do_bus), .ext_addr(bus.ext_addr), .ext_fitted,
      .bank_enable_n, .access_req, .ext_addr_latch_clk, .ext_latch);

   // ==========================================================================
   // Clock, timeout and checks
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         results();
      end
   end

   task automatic results;
      $display("Checks %0d, errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Select table contents; bit set means selected
   function automatic logic [3:0] ent(input logic [7:0] i);
      return i[3:0] ^ i[7:4] ^ 4'h6;
   endfunction

   function automatic logic expb(input logic [7:0] s);
      logic [3:0] e;
      e = ent(s);
      if (decoded_form && $countones(s) > 1)
         return 1'b1;
      return ~e[out_sel];
   endfunction

   // ==========================================================================
   // Link and programming port drivers
   task automatic prog(input logic [1:0] t, input logic [7:0] a, input logic [3:0] d);
      @(posedge mclk);
      prog_we <= 1'b1;
      prog_table <= t;
      prog_addr <= a;
      prog_data <= d;
      @(posedge mclk);
      prog_we <= 1'b0;
   endtask

   // Holds the request until done; samples the board late in sync, after the PHASE 2 fall update
   task automatic cmd(input xbs_cmd_type k, input logic [15:0] a, input logic [7:0] d);
      int n;
      int p;
      n = 0;
      p = 0;
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_kind <= k;
      cmd_addr <= a;
      cmd_data <= d;
      while (cmd_done !== 1'b1 && n < 400) begin
         @(negedge mclk);
         n++;
         if (bus.psync === 1'b1)
            p++;
         if (p == 1)
            chk_bit(cmd_ready, 1'b0);
         if (p == 40) begin
            mid_bank = bank_enable_n;
            mid_acc = access_req;
         end
      end
      // A command that never finishes counts as a mismatch
      chk_bit(cmd_done, 1'b1);
      @(posedge mclk);
      cmd_valid <= 1'b0;
      repeat (8) @(posedge mclk);
   endtask

   task automatic rst;
      @(posedge mclk);
      srst <= 1'b1;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      repeat (4) @(posedge mclk);
      chk_bit(bank_enable_n, `XBS_BANK_EN_N_RST);
      chk_byte(ext_latch, `XBS_LATCH_RST);
   endtask

   // ==========================================================================
   // Main sequence
   initial begin
      int i;
      int k;
      {cmd_valid, phantom_req, prog_we, ext_fitted, src_latch, decoded_form, a11_invert} = '0;
      {disables_as_inputs, memory_selected_n, board_select_n} = '0;
      {cmd_addr, cmd_data, block_switch, prog_addr, strobe_sel, prog_data, out_sel, prog_table} = '0;
      cmd_kind = XBS_CMD_LINES;
      srst = 1'b1;
      repeat (2) @(posedge mclk);
      rst();
      for (i = 0; i < 256; i++) prog(`XBS_TBL_SELECT, i[7:0], ent(i[7:0]));
      for (i = 0; i < 256; i++) prog(`XBS_TBL_DISABLE, i[7:0], {2'b00, i == 'hE5 || i == 'hF5, i == 'hF3});
      for (i = 0; i < 16; i++) prog(`XBS_TBL_PORT_HI, i[7:0], {3'b000, i == 12});
      cmd(XBS_CMD_LINES, 16'h0000, 8'h11);
      chk_bit(bank_enable_n, 1'b0);
      @(posedge mclk);
      ext_fitted <= 1'b1;
      for (k = 0; k < 4; k++) for (i = 0; i < 4; i++) begin
         @(posedge mclk);
         out_sel <= k[1:0];
         phantom_req <= i[0];
         v = 8'(k * 37 + i * 9 + 32);
         cmd(XBS_CMD_LINES, 16'h0000, v);
         chk_bit(bank_enable_n, expb(v));
      end
      @(posedge mclk);
      decoded_form <= 1'b1;
      phantom_req <= 1'b0;
      for (i = 0; i < 5; i++) begin
         v = one_hot[i];
         cmd(XBS_CMD_LINES, 16'h0000, v);
         chk_bit(bank_enable_n, expb(v));
      end
      @(posedge mclk);
      strobe_sel <= 4'h9;
      decoded_form <= 1'b0;
      for (i = 0; i < 4; i++) begin
         @(posedge mclk);
         block_switch <= blk_sw[i];
         cmd(XBS_CMD_SYNC, blk_addr[i], 8'h44);
         chk_bit(mid_bank, blk_dis[i] | expb(v));
         chk_bit(mid_acc, ~(blk_dis[i] | expb(v)));
      end
      chk_byte(ext_latch, 8'h00);
      @(posedge mclk);
      disables_as_inputs <= 1'b1;
      board_select_n <= 1'b1;
      block_switch <= 8'h53;
      cmd(XBS_CMD_SYNC, 16'hF000, 8'h44);
      chk_bit(mid_bank, expb({2'b11, v[5:0]}));
      chk_bit(mid_acc, 1'b0);
      @(posedge mclk);
      disables_as_inputs <= 1'b0;
      board_select_n <= 1'b0;
      ext_fitted <= 1'b0;
      rst();
      @(posedge mclk);
      ext_fitted <= 1'b1;
      src_latch <= 1'b1;
      strobe_sel <= 4'h0;
      v = 8'h5A;
      cmd(XBS_CMD_SYNC, 16'h0000, v);
      chk_byte(ext_latch, v);
      chk_bit(bank_enable_n, expb(v));
      for (k = 0; k < 8; k++) begin
         @(posedge mclk);
         strobe_sel <= 4'(k + 1);
         v = 8'h90 + 8'(k);
         cmd(XBS_CMD_OUT, {4'hC, 1'b1, 3'(k), 8'h00}, v);
         chk_byte(ext_latch, v);
         chk_bit(bank_enable_n, expb(v));
      end
      for (i = 0; i < 3; i++) begin
         cmd(XBS_CMD_OUT, bad_addr[i], 8'h33);
         chk_byte(ext_latch, v);
      end
      @(posedge mclk);
      a11_invert <= 1'b1;
      cmd(XBS_CMD_OUT, 16'hC700, 8'h66);
      chk_byte(ext_latch, 8'h66);
      results();
   end
endmodule

/* dv/xbs_asserts.sv */
// Concurrent checks on the bank select link and the board end outputs
`timescale 1ns/1ps
module xbs_asserts (
   input wire logic mclk,
   input wire logic srst,
   input wire logic phase2,
   input wire logic psync,
   input wire logic pwr_n,
   input wire logic sout,
   input wire logic [15:0] addr,
   input wire logic [7:0] do_bus,
   input wire logic [7:0] ext_addr,
   input wire logic ext_fitted,
   input wire logic bank_enable_n,
   input wire logic access_req,
   input wire logic ext_addr_latch_clk,
   input wire logic [7:0] ext_latch
);
   // ==========================================================================
   // Cycles since the last event allowed to move the bank enable
   logic [3:0] quiet_q;

   always_ff @(posedge mclk) begin
      if (srst || ($fell(phase2) && psync) || ($fell(pwr_n) && sout) || $changed(addr) || $changed(ext_addr)
          || $changed(ext_fitted)) begin
         quiet_q <= 4'h0;
      end else if (quiet_q != 4'hF) begin
         quiet_q <= quiet_q + 4'h1;
      end
   end

   // ==========================================================================
   // Properties
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   chk_psync_period: assert property ($rose(psync) |-> ##50 $fell(psync))
      else $error("psync not one bus clock long");
   chk_psync_edge: assert property ($rose(psync) |-> $rose(phase2))
      else $error("psync rose away from a phase2 rise");
   chk_pwr_in_out: assert property (!pwr_n |-> sout)
      else $error("write strobe outside output status");
   chk_pwr_period: assert property ($fell(pwr_n) |-> ##50 $rose(pwr_n))
      else $error("write strobe not one bus clock long");
   chk_bank_timing: assert property ($changed(bank_enable_n) |-> quiet_q < 4'hC)
      else $error("bank enable moved without a cause");
   chk_latch_cause: assert property (ext_addr_latch_clk |-> quiet_q < 4'hC ##1 !ext_addr_latch_clk)
      else $error("latch clock without strobe or too long");
   chk_latch_data: assert property (ext_addr_latch_clk |-> ext_latch == do_bus)
      else $error("latch does not hold the data bus");
   chk_latch_hold: assert property ($changed(ext_latch) |-> ext_addr_latch_clk)
      else $error("latch changed without its clock");
   chk_no_ext: assert property (!ext_fitted ##1 !ext_fitted |-> !bank_enable_n)
      else $error("bank enable not active without extension");
   chk_access_req: assert property (access_req |-> ($past(psync, 2) || $past(psync, 3) || $past(psync, 4)))
      else $error("access request outside sync");
endmodule

/* inc/xbs_defs.svh */
// Constants for the extended bank select link and both of its ends
// ==========================================================================
// Operation
// - Encoded address: n lines give 2^n banks
// - Decoded address: one line or none active
// - Source: bus lines, port write, sync capture
// - Reduce address to one active-low bank enable
// - Deselected: ignore accesses, refresh continues
// - Bank enable independent of PHANTOM
// - No extension fitted: enable held active
// - Eight inputs, two disables, four outputs
// - Latch takes DO on clock rising edge
// - Latch clock from nine jumpered sources
// - Sync option: capture after PHASE 2 fall
// - Host itself drives DO during sync
// - Port option: capture at PWR fall
// - A8 to A10 pick the port strobe
// - A11 true or inverted by jumper
// - A12 to A15 matched by decode table
// - Disables: function of A12-A15 and switches
// - Optional: disables tied, decodes become inputs
// - Bank enable stable while being used
// - May change at PHASE 2 fall in sync
// - May change at PWR fall, or address change
// - Access needs sync and three selects low
`ifndef XBS_DEFS_SVH
`define XBS_DEFS_SVH

// ==========================================================================
// Timing
`define XBS_MCLK_NS 10
`define XBS_P2_HALF_NS 250
`define XBS_P2_HALF_CYC (`XBS_P2_HALF_NS / `XBS_MCLK_NS)

// ==========================================================================
// Table selectors on the programming port
`define XBS_TBL_SELECT 2'h0
`define XBS_TBL_DISABLE 2'h1
`define XBS_TBL_PORT_HI 2'h2

// ==========================================================================
// Strobe choice: 0 is the sync strobe, 1 to 8 the port strobes
`define XBS_STROBE_SYNC 4'h0
`define XBS_STROBE_PORTS 4'h8

// ==========================================================================
// Field positions on the address bus
`define XBS_PORT_LO_MSB 10
`define XBS_PORT_LO_LSB 8
`define XBS_PORT_B3 11
`define XBS_BLOCK_MSB 15
`define XBS_BLOCK_LSB 12

// ==========================================================================
// Reset values
`define XBS_LATCH_RST 8'h00
`define XBS_BANK_EN_N_RST 1'b0

`endif

/* inc/xbs_if.sv */
// Bus link between the bank controller end and the memory board end
`timescale 1ns/1ps
interface xbs_if;
   logic phase2;
   logic psync;
   logic pwr_n;
   logic sout;
   logic phantom;
   logic [15:0] addr;
   logic [7:0] do_bus;
   logic [7:0] ext_addr;

   modport host (
      output phase2,
      output psync,
      output pwr_n,
      output sout,
      output phantom,
      output addr,
      output do_bus,
      output ext_addr
   );

   modport device (
      input phase2,
      input psync,
      input pwr_n,
      input sout,
      input phantom,
      input addr,
      input do_bus,
      input ext_addr
   );
endinterface

/* inc/xbs_pkg.sv */
// Types shared by the bank select link ends
package xbs_pkg;
   typedef enum logic [1:0] {
      XBS_CMD_LINES = 2'h0,
      XBS_CMD_SYNC = 2'h1,
      XBS_CMD_OUT = 2'h2
   } xbs_cmd_type;

   typedef enum logic [2:0] {
      XBS_H_IDLE = 3'h0,
      XBS_H_SYNC = 3'h1,
      XBS_H_SOUT = 3'h2,
      XBS_H_WR = 3'h3,
      XBS_H_END = 3'h4
   } xbs_host_state_type;
endpackage

/* verilog/xbs_device.sv */
// Memory board end: extended selection logic producing the bank enable
`timescale 1ns/1ps
`include "xbs_defs.svh"
module xbs_device
   import xbs_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   xbs_if.device bus,
   input wire logic ext_fitted,
   input wire logic src_latch,
   input wire logic decoded_form,
   input wire logic [3:0] strobe_sel,
   input wire logic a11_invert,
   input wire logic [1:0] out_sel,
   input wire logic disables_as_inputs,
   input wire logic [7:0] block_switch,
   input wire logic memory_selected_n,
   input wire logic board_select_n,
   input wire logic prog_we,
   input wire logic [1:0] prog_table,
   input wire logic [7:0] prog_addr,
   input wire logic [3:0] prog_data,
   output logic bank_enable_n,
   output logic access_req,
   output logic ext_addr_latch_clk,
   output logic [7:0] ext_latch
);
   // ========================================================================
   // Programmable tables
   logic [3:0] select_rom [0:255];
   logic [1:0] disable_rom [0:255];
   logic port_hi_rom [0:15];

   // ========================================================================
   // Pin synchronisers
   logic [1:0] p2_sy_q;
   logic [1:0] psync_sy_q;
   logic [1:0] pwr_n_sy_q;
   logic [1:0] sout_sy_q;
   logic [15:0] addr_sy0_q;
   logic [15:0] addr_sy1_q;
   logic [7:0] do_sy0_q;
   logic [7:0] do_sy1_q;
   logic [7:0] ext_sy0_q;
   logic [7:0] ext_sy1_q;
   logic p2_prev_q;
   logic pwr_n_prev_q;
   logic [15:0] addr_prev_q;
   logic [7:0] ext_prev_q;

   logic sync_fall;
   logic pwr_fall;
   logic addr_moved;
   logic [8:0] strobes;
   logic latch_strobe;
   logic [7:0] latch_q;
   logic update_q;
   logic bank_en_n_q;
   logic access_q;
   logic xclk_q;
   logic [7:0] sel_in;
   logic [1:0] dis_lines;
   logic [3:0] rom_out;
   logic chosen;
   logic next_en_n;

   // Pop count above one marks an illegal decoded address
   function automatic logic many_hot(input logic [7:0] v);
      logic seen;
      logic more;
      seen = 1'b0;
      more = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (v[i]) begin
            more = more | seen;
            seen = 1'b1;
         end
      end
      return more;
   endfunction

   always_ff @(posedge mclk) begin
      if (prog_we && prog_table == `XBS_TBL_SELECT) begin
         select_rom[prog_addr] <= prog_data;
      end
      if (prog_we && prog_table == `XBS_TBL_DISABLE) begin
         disable_rom[prog_addr] <= prog_data[1:0];
      end
      if (prog_we && prog_table == `XBS_TBL_PORT_HI) begin
         port_hi_rom[prog_addr[3:0]] <= prog_data[0];
      end
   end

   // Only the second stage of each synchroniser is read by logic
   always_ff @(posedge mclk) begin
      if (srst) begin
         p2_sy_q <= 2'h0;
         psync_sy_q <= 2'h0;
         pwr_n_sy_q <= 2'h3;
         sout_sy_q <= 2'h0;
         addr_sy0_q <= 16'h0000;
         addr_sy1_q <= 16'h0000;
         do_sy0_q <= 8'h00;
         do_sy1_q <= 8'h00;
         ext_sy0_q <= 8'h00;
         ext_sy1_q <= 8'h00;
      end else begin
         p2_sy_q <= {p2_sy_q[0], bus.phase2};
         psync_sy_q <= {psync_sy_q[0], bus.psync};
         pwr_n_sy_q <= {pwr_n_sy_q[0], bus.pwr_n};
         sout_sy_q <= {sout_sy_q[0], bus.sout};
         addr_sy0_q <= bus.addr;
         addr_sy1_q <= addr_sy0_q;
         do_sy0_q <= bus.do_bus;
         do_sy1_q <= do_sy0_q;
         ext_sy0_q <= bus.ext_addr;
         ext_sy1_q <= ext_sy0_q;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         p2_prev_q <= 1'b0;
         pwr_n_prev_q <= 1'b1;
         addr_prev_q <= 16'h0000;
         ext_prev_q <= 8'h00;
      end else begin
         p2_prev_q <= p2_sy_q[1];
         pwr_n_prev_q <= pwr_n_sy_q[1];
         addr_prev_q <= addr_sy1_q;
         ext_prev_q <= ext_sy1_q;
      end
   end

   // ========================================================================
   // Latch clock sources
   assign sync_fall = p2_prev_q && !p2_sy_q[1] && psync_sy_q[1];
   assign pwr_fall = pwr_n_prev_q && !pwr_n_sy_q[1] && sout_sy_q[1];
   assign addr_moved = (addr_prev_q != addr_sy1_q) || (ext_prev_q != ext_sy1_q);

   assign strobes[0] = sync_fall;
   generate
      for (genvar g = 0; g < 8; g++) begin : g_port
         // Decoder enabled by A11 polarity and the high nibble table
         assign strobes[g + 1] = pwr_fall
            && (addr_sy1_q[`XBS_PORT_LO_MSB:`XBS_PORT_LO_LSB] == 3'(g))
            && (addr_sy1_q[`XBS_PORT_B3] ^ a11_invert)
            && port_hi_rom[addr_sy1_q[`XBS_BLOCK_MSB:`XBS_BLOCK_LSB]];
      end
   endgenerate

   // Out-of-range jumper choice selects no source
   assign latch_strobe = (strobe_sel <= `XBS_STROBE_PORTS) && strobes[strobe_sel];

   // ========================================================================
   // Extended address latch
   always_ff @(posedge mclk) begin
      if (srst) begin
         latch_q <= `XBS_LATCH_RST;
      end else if (latch_strobe) begin
         latch_q <= do_sy1_q;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         xclk_q <= 1'b0;
      end else begin
         xclk_q <= latch_strobe;
      end
   end

   // ========================================================================
   // Selection function
   always_comb begin
      // Source jumper: dedicated lines or the latch
      sel_in = src_latch ? latch_q : ext_sy1_q;
      dis_lines = disable_rom[{addr_sy1_q[`XBS_BLOCK_MSB:`XBS_BLOCK_LSB], block_switch[3:0]}];
      dis_lines[1] = disable_rom[{addr_sy1_q[`XBS_BLOCK_MSB:`XBS_BLOCK_LSB], block_switch[7:4]}][1];
      if (disables_as_inputs) begin
         sel_in[7:6] = dis_lines;
      end
      // Table indexed by the binary value of the address lines
      rom_out = select_rom[sel_in];
      chosen = rom_out[out_sel];
      next_en_n = 1'b1;
      if (!ext_fitted) begin
         next_en_n = 1'b0;
      end else if (decoded_form && many_hot(sel_in)) begin
         next_en_n = 1'b1;
      end else if (!disables_as_inputs && (dis_lines != 2'h0)) begin
         next_en_n = 1'b1;
      end else begin
         next_en_n = !chosen;
      end
   end

   // ========================================================================
   // Bank enable update, only at the permitted moments
   always_ff @(posedge mclk) begin
      if (srst) begin
         update_q <= 1'b0;
      end else begin
         update_q <= sync_fall || pwr_fall || addr_moved;
      end
   end

   // PHANTOM is not an input to this path at all
   always_ff @(posedge mclk) begin
      if (srst) begin
         bank_en_n_q <= `XBS_BANK_EN_N_RST;
      end else if (update_q || !ext_fitted) begin
         bank_en_n_q <= next_en_n;
      end
   end

   // ========================================================================
   // Access request; refresh logic elsewhere never looks at it
   always_ff @(posedge mclk) begin
      if (srst) begin
         access_q <= 1'b0;
      end else begin
         access_q <= psync_sy_q[1] && !memory_selected_n && !board_select_n
            && !bank_en_n_q;
      end
   end

   assign bank_enable_n = bank_en_n_q;
   assign access_req = access_q;
   assign ext_addr_latch_clk = xclk_q;
   assign ext_latch = latch_q;
endmodule

/* verilog/xbs_host.sv */
// Bank controller end: drives PHASE 2, sync, output cycles and extended lines
`timescale 1ns/1ps
`include "xbs_defs.svh"
module xbs_host
   import xbs_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   xbs_if.host bus,
   input wire logic cmd_valid,
   input wire xbs_cmd_type cmd_kind,
   input wire logic [15:0] cmd_addr,
   input wire logic [7:0] cmd_data,
   input wire logic phantom_req,
   output logic cmd_ready,
   output logic cmd_done
);
   localparam logic [7:0] HALF_CYC = 8'(`XBS_P2_HALF_CYC);

   logic [7:0] div_q;
   logic phase2_q;
   logic p2_rise;
   xbs_host_state_type state_q;
   logic psync_q;
   logic pwr_n_q;
   logic sout_q;
   logic phantom_q;
   logic [15:0] addr_q;
   logic [7:0] do_q;
   logic [7:0] ext_q;
   xbs_cmd_type kind_q;

   // ========================================================================
   // PHASE 2 divider
   assign p2_rise = (div_q == HALF_CYC - 8'h01) && !phase2_q;

   always_ff @(posedge mclk) begin
      if (srst || div_q == HALF_CYC - 8'h01) begin
         div_q <= 8'h00;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         phase2_q <= 1'b0;
      end else if (div_q == HALF_CYC - 8'h01) begin
         phase2_q <= !phase2_q;
      end
   end

   // ========================================================================
   // Bus cycle sequencer, stepped on PHASE 2 rise so each fall lands mid-state
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_q <= XBS_H_IDLE;
         psync_q <= 1'b0;
         pwr_n_q <= 1'b1;
         sout_q <= 1'b0;
         addr_q <= 16'h0000;
         do_q <= 8'h00;
         ext_q <= 8'h00;
         kind_q <= XBS_CMD_LINES;
         cmd_done <= 1'b0;
      end else begin
         cmd_done <= 1'b0;
         if (p2_rise) begin
            unique case (state_q)
               XBS_H_IDLE: begin
                  if (cmd_valid) begin
                     kind_q <= cmd_kind;
                     addr_q <= cmd_addr;
                     do_q <= cmd_data;
                     if (cmd_kind == XBS_CMD_LINES) begin
                        ext_q <= cmd_data;
                        state_q <= XBS_H_END;
                     end else begin
                        psync_q <= 1'b1;
                        state_q <= XBS_H_SYNC;
                     end
                  end
               end
               XBS_H_SYNC: begin
                  psync_q <= 1'b0;
                  if (kind_q == XBS_CMD_OUT) begin
                     sout_q <= 1'b1;
                     state_q <= XBS_H_SOUT;
                  end else begin
                     state_q <= XBS_H_END;
                  end
               end
               XBS_H_SOUT: begin
                  pwr_n_q <= 1'b0;
                  state_q <= XBS_H_WR;
               end
               XBS_H_WR: begin
                  pwr_n_q <= 1'b1;
                  state_q <= XBS_H_END;
               end
               XBS_H_END: begin
                  sout_q <= 1'b0;
                  cmd_done <= 1'b1;
                  state_q <= XBS_H_IDLE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         cmd_ready <= 1'b0;
         phantom_q <= 1'b0;
      end else begin
         cmd_ready <= (state_q == XBS_H_IDLE) && !p2_rise;
         phantom_q <= phantom_req;
      end
   end

   // DO carries the extended address during sync as well
   assign bus.phase2 = phase2_q;
   assign bus.psync = psync_q;
   assign bus.pwr_n = pwr_n_q;
   assign bus.sout = sout_q;
   assign bus.phantom = phantom_q;
   assign bus.addr = addr_q;
   assign bus.do_bus = do_q;
   assign bus.ext_addr = ext_q;
endmodule
